// ===== design/mdc_regs.svh
// Constants of the multichannel converter control port
`ifndef MDC_REGS_SVH
`define MDC_REGS_SVH
// ----------------------------------------
// Widths and channel numbers
// ----------------------------------------
`define MDC_CODE_W 14
`define MDC_NCH 32
`define MDC_OFFS_CH 6'h20
`define MDC_ALL_CH 6'h3F
`define MDC_FRAME_BITS 5'h14
// ----------------------------------------
// Synchronised pin vector layout
// ----------------------------------------
`define MDC_P_ADDR 4:0
`define MDC_P_OFFS 5
`define MDC_P_WRN 6
`define MDC_P_CSN 7
`define MDC_P_CAL 8
`define MDC_P_IFC 9
`define MDC_P_SCLK 10
`define MDC_P_DIN 11
`define MDC_P_TRK 12
`define MDC_P_SHO 13
`define MDC_PIN_RST 14'h189F
// ----------------------------------------
// Timing
// ----------------------------------------
`define MDC_CLK_NS 100
`define MDC_ACQ_NS 16000
`define MDC_RST_MIN_NS 90
`define MDC_RST_MAX_NS 200
`define MDC_ACQ_CYC (`MDC_ACQ_NS / `MDC_CLK_NS)
`define MDC_RST_MIN_CYC ((`MDC_RST_MIN_NS + `MDC_CLK_NS - 1) / `MDC_CLK_NS)
`define MDC_RST_MAX_CYC (`MDC_RST_MAX_NS / `MDC_CLK_NS)
`endif

// ===== design/mdc_pkg.sv
// Types and helpers of the multichannel converter control port
package mdc_pkg;
  typedef logic [13:0] mdc_code_t;
  typedef logic [5:0] mdc_chan_t;
  typedef enum logic [2:0] {
    MDC_IDLE = 3'h1,
    MDC_ACQ = 3'h2,
    MDC_TRACK = 3'h4
  } mdc_state_t;

  // Offset select overrides the five address bits
  function automatic mdc_chan_t mdc_chan_of(input logic offs, input logic [4:0] addr);
    mdc_chan_of = offs ? 6'h20 : {1'b0, addr};
  endfunction : mdc_chan_of
endpackage : mdc_pkg

// ===== design/mdc_port.sv
// Control port: parallel and serial access, acquisition, track and reset
`timescale 1ns/1ns
`include "mdc_regs.svh"
module mdc_port
  import mdc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [4:0] channel_number_inputs,
  input wire logic offset_sel,
  input wire logic wr_n,
  input wire logic cs_sync_n,
  input wire logic acquire_all,
  input wire logic interface_choice,
  input wire logic serial_clk,
  input wire logic serial_din,
  input wire logic track_rst_n,
  input wire logic sample_hold_operation,
  input wire logic [13:0] analog_input,
  output logic busy_n,
  output logic serial_dout,
  output logic upd_valid,
  output logic [5:0] upd_chan,
  output logic [13:0] upd_code,
  output logic track_route,
  output logic [5:0] track_chan,
  output logic [13:0] zero_shift_output
);
  localparam int ACQ_N = `MDC_ACQ_CYC;
  localparam logic [7:0] ACQ_LAST = 8'(`MDC_ACQ_CYC - 1);
  localparam logic [1:0] RMIN = 2'(`MDC_RST_MIN_CYC);
  localparam logic [1:0] RMAX = 2'(`MDC_RST_MAX_CYC);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [13:0] pin_raw;
  logic [13:0] s1_q;
  logic [13:0] s2_q;
  logic [13:0] s3_q;
  assign pin_raw = {sample_hold_operation, track_rst_n, serial_din, serial_clk,
                    interface_choice, acquire_all, cs_sync_n, wr_n, offset_sel,
                    channel_number_inputs};

  // Third stage only feeds the edge detectors
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_q <= `MDC_PIN_RST;
      s2_q <= `MDC_PIN_RST;
      s3_q <= `MDC_PIN_RST;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic ser_mode;
  logic frame;
  logic frame_start;
  logic frame_end;
  logic sclk_fall;
  logic sclk_rise;
  logic par_go;
  logic cal_go;
  logic trk_rise;
  mdc_chan_t par_ch;
  assign ser_mode = s2_q[`MDC_P_IFC];
  assign frame = ser_mode && !s2_q[`MDC_P_CSN];
  assign frame_start = frame && s3_q[`MDC_P_CSN];
  assign frame_end = ser_mode && s2_q[`MDC_P_CSN] && !s3_q[`MDC_P_CSN];
  assign sclk_fall = !s2_q[`MDC_P_SCLK] && s3_q[`MDC_P_SCLK];
  assign sclk_rise = s2_q[`MDC_P_SCLK] && !s3_q[`MDC_P_SCLK];
  assign par_go = !ser_mode && !s2_q[`MDC_P_CSN] && !s2_q[`MDC_P_WRN]
                  && (s3_q[`MDC_P_CSN] || s3_q[`MDC_P_WRN]);
  assign cal_go = !ser_mode && s2_q[`MDC_P_CAL] && !s3_q[`MDC_P_CAL];
  assign par_ch = mdc_chan_of(s2_q[`MDC_P_OFFS], s2_q[`MDC_P_ADDR]);
  assign trk_rise = s2_q[`MDC_P_TRK] && !s3_q[`MDC_P_TRK];

  // ----------------------------------------
  // Code memory
  // ----------------------------------------
  mdc_code_t code_q [0:32];
  mdc_chan_t rb_ch_q;
  mdc_code_t rb_code;
  assign rb_code = code_q[rb_ch_q];

  // ----------------------------------------
  // Serial shifter
  // ----------------------------------------
  logic [19:0] shin_q;
  logic [19:0] shin_d;
  logic [4:0] bits_q;
  logic [4:0] bits_d;
  mdc_code_t shout_q;
  mdc_code_t shout_d;
  logic dout_q;
  logic dout_d;
  logic ser_wr;
  mdc_chan_t ser_ch;
  assign ser_ch = mdc_chan_of(shin_q[19], shin_q[18:14]);
  assign ser_wr = frame_end && bits_q == `MDC_FRAME_BITS;

  always_comb begin
    shin_d = shin_q;
    bits_d = bits_q;
    shout_d = shout_q;
    dout_d = dout_q;
    if (frame_start) begin
      bits_d = 5'h00;
      shout_d = rb_code;
    end else if (frame) begin
      if (sclk_fall && bits_q != `MDC_FRAME_BITS) begin
        shin_d = {shin_q[18:0], s2_q[`MDC_P_DIN]};
        bits_d = bits_q + 5'h01;
      end
      if (sclk_rise) begin
        dout_d = shout_q[13];
        shout_d = {shout_q[12:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Acquisition, track and soft reset
  // ----------------------------------------
  mdc_state_t st_q;
  mdc_state_t st_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [1:0] low_q;
  logic [1:0] low_d;
  mdc_chan_t sel_q;
  mdc_chan_t sel_d;
  logic all_q;
  logic all_d;
  logic soft_rst;
  logic req;
  logic req_all;
  mdc_chan_t req_ch;
  logic wr_en;
  logic wr_all;
  mdc_chan_t wr_ch;
  mdc_code_t wr_code;
  mdc_chan_t rb_ch_d;

  assign soft_rst = trk_rise && low_q >= RMIN && low_q <= RMAX;
  assign req = par_go || cal_go || (ser_wr && s2_q[`MDC_P_SHO]);
  assign req_all = cal_go && !par_go;
  assign req_ch = par_go ? par_ch : ser_ch;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sel_d = sel_q;
    all_d = all_q;
    rb_ch_d = rb_ch_q;
    low_d = 2'h0;
    wr_en = 1'b0;
    wr_all = 1'b0;
    wr_ch = sel_q;
    wr_code = analog_input;
    if (!s2_q[`MDC_P_TRK]) begin
      low_d = (low_q == 2'h3) ? low_q : low_q + 2'h1;
    end
    if (ser_wr) begin
      rb_ch_d = ser_ch;
    end
    unique case (st_q)
      MDC_IDLE: begin
        if (req) begin
          sel_d = req_ch;
          all_d = req_all;
          if (s2_q[`MDC_P_TRK]) begin
            st_d = MDC_ACQ;
            cnt_d = 8'h00;
          end
        end else if (low_q > RMAX && trk_rise) begin
          st_d = MDC_ACQ;
          cnt_d = 8'h00;
        end else if (low_q > RMAX) begin
          st_d = MDC_TRACK;
        end
        if (ser_wr && !s2_q[`MDC_P_SHO]) begin
          wr_en = 1'b1;
          wr_ch = ser_ch;
          wr_code = shin_q[13:0];
        end
      end
      MDC_ACQ: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == ACQ_LAST) begin
          st_d = MDC_IDLE;
          wr_en = 1'b1;
          wr_all = all_q;
        end
      end
      MDC_TRACK: begin
        if (req) begin
          sel_d = req_ch;
          all_d = req_all;
        end
        if (trk_rise) begin
          st_d = MDC_ACQ;
          cnt_d = 8'h00;
        end
      end
      default: begin
        st_d = MDC_IDLE;
      end
    endcase
  end

  // Soft reset clears the same state as the reset pin except the pin synchronisers
  always_ff @(posedge clk_sys) begin
    if (!rst_n || soft_rst) begin
      for (int i = 0; i <= `MDC_NCH; i++) begin
        code_q[i] <= '0;
      end
      shin_q <= '0;
      bits_q <= 5'h00;
      shout_q <= '0;
      dout_q <= 1'b0;
      st_q <= MDC_IDLE;
      cnt_q <= 8'h00;
      low_q <= 2'h0;
      sel_q <= 6'h00;
      all_q <= 1'b0;
      rb_ch_q <= 6'h00;
      busy_n <= 1'b1;
      serial_dout <= 1'b0;
      upd_valid <= 1'b0;
      upd_chan <= 6'h00;
      upd_code <= '0;
      track_route <= 1'b0;
      track_chan <= 6'h00;
      zero_shift_output <= '0;
    end else begin
      if (wr_en) begin
        for (int i = 0; i < `MDC_NCH; i++) begin
          if (wr_all || wr_ch == 6'(i)) begin
            code_q[i] <= wr_code;
          end
        end
        if (!wr_all && wr_ch == `MDC_OFFS_CH) begin
          code_q[32] <= wr_code;
          zero_shift_output <= wr_code;
        end
      end
      shin_q <= shin_d;
      bits_q <= bits_d;
      shout_q <= shout_d;
      dout_q <= dout_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
      sel_q <= sel_d;
      all_q <= all_d;
      rb_ch_q <= rb_ch_d;
      busy_n <= st_d != MDC_ACQ;
      serial_dout <= dout_d;
      upd_valid <= wr_en;
      upd_chan <= wr_all ? `MDC_ALL_CH : wr_ch;
      upd_code <= wr_code;
      track_route <= st_d != MDC_IDLE;
      track_chan <= sel_d;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_busy_len;
    disable iff (!rst_n || soft_rst)
    $fell(busy_n) |-> ##[ACQ_N:ACQ_N] $rose(busy_n);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("acquisition length wrong");

  property p_busy_low;
    disable iff (!rst_n || soft_rst)
    $fell(busy_n) |-> !busy_n [*8];
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy rose early");

  property p_end_upd;
    $rose(busy_n) && !$past(soft_rst) |-> upd_valid && upd_code == $past(analog_input);
  endproperty
  a_end_upd: assert property (p_end_upd) else $error("no code update at end");

  property p_soft_rst;
    soft_rst |=> busy_n && zero_shift_output == '0 && !track_route;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("short pulse did not reset");

  property p_long_low;
    st_q == MDC_TRACK && trk_rise && !soft_rst |=> !busy_n;
  endproperty
  a_long_low: assert property (p_long_low) else $error("track end did not acquire");

  property p_track_route;
    st_q == MDC_IDLE && low_q == 2'h3 && !req |=> track_route;
  endproperty
  a_track_route: assert property (p_track_route) else $error("input not routed");

  property p_par_cap;
    par_go && s2_q[`MDC_P_TRK] && st_q == MDC_IDLE && !soft_rst
      |=> !busy_n && track_chan == $past(par_ch);
  endproperty
  a_par_cap: assert property (p_par_cap) else $error("parallel address lost");

  property p_readback;
    frame_start && !soft_rst |=> shout_q == $past(rb_code);
  endproperty
  a_readback: assert property (p_readback) else $error("readback code wrong");

  property p_ser_in;
    frame && !frame_start && sclk_fall && bits_q != `MDC_FRAME_BITS && !soft_rst
      |=> shin_q[0] == $past(s2_q[`MDC_P_DIN]);
  endproperty
  a_ser_in: assert property (p_ser_in) else $error("serial bit not sampled");

  property p_cal_all;
    $rose(busy_n) && $past(all_q) && !$past(soft_rst) |-> upd_chan == `MDC_ALL_CH;
  endproperty
  a_cal_all: assert property (p_cal_all) else $error("acquire-all not broadcast");

  property p_offs;
    upd_valid && upd_chan == `MDC_OFFS_CH |-> zero_shift_output == upd_code;
  endproperty
  a_offs: assert property (p_offs) else $error("offset output stale");

  property p_wr_gate;
    !ser_mode && s2_q[`MDC_P_WRN] && !cal_go && !trk_rise && st_q == MDC_IDLE |=> busy_n;
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("access without write strobe");

  c_par: cover property (par_go ##1 !busy_n);
  c_all: cover property (cal_go ##1 !busy_n);
  c_ser: cover property (ser_wr);
  c_rst: cover property (soft_rst);
  c_trk: cover property (st_q == MDC_TRACK ##1 trk_rise);
endmodule : mdc_port

// ===== tb/mdc_host.sv
// Host model: serial frame sender with readback capture
`timescale 1ns/1ns
module mdc_host (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [19:0] word,
  input wire logic dout,
  output logic sclk = 1'b0,
  output logic din = 1'b1,
  output logic sync_n = 1'b1,
  output logic busy = 1'b0,
  output logic [19:0] rd = 20'h00000
);
  int cnt = 0;
  // Bit period of 8 system cycles, clock stands low outside frames
  always @(posedge clk_sys) begin
    if (go && !busy) begin
      busy <= 1'b1;
      sync_n <= 1'b0;
      cnt <= 0;
    end else if (busy) begin
      cnt <= cnt + 1;
      if (cnt >= 4 && cnt < 164 && cnt % 8 == 4) begin
        sclk <= 1'b1;
        din <= word[19 - (cnt - 4) / 8];
      end
      if (cnt >= 8 && cnt < 164 && cnt % 8 == 0) begin
        sclk <= 1'b0;
        rd <= {rd[18:0], dout};
      end
      if (cnt == 168) begin
        sync_n <= 1'b1;
        din <= 1'b1;
      end
      if (cnt == 172) begin
        busy <= 1'b0;
      end
    end
  end
endmodule : mdc_host

// ===== tb/tb_mdc_port.sv
// Testbench of the control port
`timescale 1ns/1ns
module tb_mdc_port;
  import mdc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr = 5'h1F;
  logic offs = 1'b0;
  logic wr_n = 1'b0;
  logic cs_n = 1'b1;
  logic cal = 1'b0;
  logic ifc = 1'b0;
  logic trk = 1'b1;
  logic sho = 1'b0;
  logic [13:0] ain = 14'h0000;
  logic go = 1'b0;
  logic [19:0] word = 20'h00000;
  logic sclk, din, h_sync, h_busy, busy_n, dout, upd_valid, track_route;
  logic [19:0] rd;
  logic [5:0] upd_chan, track_chan;
  logic [13:0] upd_code, zso;
  int n_fail = 0;
  int cmp_count = 0;
  always #50 clk_sys = ~clk_sys;
  mdc_host host (.clk_sys(clk_sys), .go(go), .word(word), .dout(dout), .sclk(sclk), .din(din),
    .sync_n(h_sync), .busy(h_busy), .rd(rd));
  mdc_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .channel_number_inputs(addr), .offset_sel(offs),
    .wr_n(wr_n), .cs_sync_n(ifc ? h_sync : cs_n), .acquire_all(cal), .interface_choice(ifc),
    .serial_clk(sclk), .serial_din(din), .track_rst_n(trk), .sample_hold_operation(sho),
    .analog_input(ain), .busy_n(busy_n), .serial_dout(dout), .upd_valid(upd_valid),
    .upd_chan(upd_chan), .upd_code(upd_code), .track_route(track_route), .track_chan(track_chan),
    .zero_shift_output(zso));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("mismatches %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wait_til(input bit on_upd, input logic lvl, output int n);
    n = 0;
    while ((on_upd ? upd_valid : busy_n) !== lvl && n < 400) begin
      tick(1);
      n++;
    end
    if (n >= 400) begin
      n_fail++;
      complete_run();
    end
  endtask : wait_til
  task automatic par_write(input logic [4:0] a, input logic o);
    @(posedge clk_sys);
    addr <= a;
    offs <= o;
    cs_n <= 1'b0;
  endtask : par_write
  task automatic acq(input logic [5:0] ch, input logic [13:0] code);
    int n;
    wait_til(1'b0, 1'b0, n);
    check(track_route, 1'b1);
    if (ch != 6'h3F) begin
      check(track_chan, ch);
    end
    wait_til(1'b0, 1'b1, n);
    check(24'(n), 24'h0000A0);
    check({upd_valid, upd_chan, upd_code}, {1'b1, ch, code});
    @(posedge clk_sys);
    cs_n <= 1'b1;
    cal <= 1'b0;
    tick(4);
  endtask : acq
  task automatic frame(input logic [19:0] w);
    int n;
    @(posedge clk_sys);
    word <= w;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    wait_til(1'b1, 1'b1, n);
  endtask : frame
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_parallel();
    @(posedge clk_sys);
    ain <= 14'h2A5C;
    wr_n <= 1'b1;
    par_write(5'h15, 1'b0);
    tick(6);
    check(busy_n, 1'b1);
    @(posedge clk_sys);
    wr_n <= 1'b0;
    acq(6'h15, 14'h2A5C);
    @(posedge clk_sys);
    ain <= 14'h0C71;
    par_write(5'h03, 1'b1);
    acq(6'h20, 14'h0C71);
    check(zso, 14'h0C71);
    @(posedge clk_sys);
    ain <= 14'h1FFF;
    cal <= 1'b1;
    acq(6'h3F, 14'h1FFF);
  endtask : t_parallel
  task automatic t_track();
    @(posedge clk_sys);
    trk <= 1'b0;
    ain <= 14'h3001;
    tick(6);
    par_write(5'h07, 1'b0);
    tick(8);
    check({busy_n, track_route}, 2'b11);
    @(posedge clk_sys);
    trk <= 1'b1;
    acq(6'h07, 14'h3001);
    check(zso, 14'h0C71);
  endtask : t_track
  task automatic t_serial();
    @(posedge clk_sys);
    ifc <= 1'b1;
    tick(4);
    frame({1'b0, 5'h0A, 14'h1234});
    check({upd_chan, upd_code}, {6'h0A, 14'h1234});
    frame({1'b0, 5'h0A, 14'h0000});
    check(rd[19:6], 14'h1234);
    @(posedge clk_sys);
    sho <= 1'b1;
    ain <= 14'h0ABC;
    frame({1'b1, 5'h00, 14'h0000});
    check({upd_chan, upd_code, zso}, {6'h20, 14'h0ABC, 14'h0ABC});
    @(posedge clk_sys);
    ifc <= 1'b0;
    sho <= 1'b0;
    tick(4);
  endtask : t_serial
  task automatic t_soft_reset();
    @(posedge clk_sys);
    trk <= 1'b0;
    @(posedge clk_sys);
    trk <= 1'b1;
    tick(8);
    check({busy_n, track_route, zso}, {1'b1, 1'b0, 14'h0000});
  endtask : t_soft_reset
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(1);
    check({busy_n, upd_valid, track_route, zso}, {1'b1, 1'b0, 1'b0, 14'h0000});
    t_parallel();
    t_track();
    t_serial();
    t_soft_reset();
    complete_run();
  end
endmodule : tb_mdc_port
